// ==== testbench/tb_udtc_top.sv ====
// Purpose: self-checking bench for the threshold counter
// Assumes: slow pulse source, AXI4-Lite master tasks
// Notes: waits cover one scan tick plus sync delay
`timescale 1ns/1ps
`default_nettype none
`include "udtc_cfg.svh"
module tb_udtc_top;
	import udtc_pkg::*;
	typedef struct {int on, off, init, up, dn, cnt; logic sw;} udtc_row_s;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic reset_in = 1'b0;
	logic power_up = 1'b0;
	logic go = 1'b0;
	logic dir = 1'b0;
	logic [7:0] num = 8'h00;
	udtc_word_t on_ext = 32'h0;
	udtc_word_t off_ext = 32'h0;
	logic count_in, dir_in, busy, switch_out;
	udtc_cnt_t count_out;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [31:0] s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int num_errors = 0;
	int total_checks = 0;
	udtc_row_s rows [7] = '{'{5, 2, 0, 6, 3, 3, 1'b1}, '{5, 2, 0, 6, 5, 1, 1'b0},
		'{3, 6, 0, 4, 0, 4, 1'b1}, '{3, 6, 0, 7, 0, 7, 1'b0}, '{3, 6, 10, 0, 3, 7, 1'b0},
		'{5, 2, 0, 0, 2, -2, 1'b0}, '{3, 6, 5, 0, 0, 5, 1'b1}};
	always #4 aclk = ~aclk;
	udtc_src i_udtc_src (.aclk, .start(go), .num, .dir, .count_in, .dir_in, .busy);
	udtc_top i_udtc_top (.*);
	task automatic summarize();
		if (num_errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bound(input int k);
		if (k >= 3000) begin
			num_errors++;
			summarize();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int k;
		k = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			k++;
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && k < 3000);
		bound(k);
		chk(s_axi_bresp, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int k;
		k = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			k++;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && k < 3000);
		bound(k);
		chk(s_axi_rdata, d);
		chk(s_axi_rresp, e);
	endtask
	task automatic pulse(input int n, input logic d);
		int k;
		k = 0;
		go <= 1'b1;
		num <= n[7:0];
		dir <= d;
		@(posedge aclk);
		go <= 1'b0;
		do begin
			@(posedge aclk);
			k++;
		end while (busy && k < 3000);
		bound(k);
		repeat (140) @(posedge aclk);
	endtask
	// Strobe power_up when p is set, otherwise the counter reset pin
	task automatic pin(input logic p);
		if (p)
			power_up <= 1'b1;
		else
			reset_in <= 1'b1;
		repeat (10) @(posedge aclk);
		power_up <= 1'b0;
		reset_in <= 1'b0;
		repeat (140) @(posedge aclk);
	endtask
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(count_out, 32'h0);
		chk(switch_out, 1'b0);
		rd(`UDTC_OFF_CTRL, 32'h8, 2'h0);
		rd(8'h20, 32'h0, 2'h2);
		wr(8'h20, 32'h1, 2'h2);
		wr(`UDTC_OFF_COUNT, 32'h1, 2'h2);
		wr(`UDTC_OFF_ON_THR, `UDTC_THR_MAX, 2'h0);
		rd(`UDTC_OFF_ON_THR, `UDTC_THR_MAX, 2'h0);
		wr(`UDTC_OFF_ON_THR, 32'h0ffffff, 2'h0);
		rd(`UDTC_OFF_ON_THR, `UDTC_THR_MAX, 2'h0);
		s_axi_wstrb <= 4'h1;
		wr(`UDTC_OFF_ON_THR, 32'hffffff03, 2'h0);
		s_axi_wstrb <= 4'hf;
		rd(`UDTC_OFF_ON_THR, 32'h00989603, 2'h0);
		foreach (rows[i]) begin
			wr(`UDTC_OFF_INIT, rows[i].init, 2'h0);
			wr(`UDTC_OFF_ON_THR, rows[i].on, 2'h0);
			wr(`UDTC_OFF_OFF_THR, rows[i].off, 2'h0);
			pin(1'b0);
			pulse(rows[i].up, 1'b0);
			pulse(rows[i].dn, 1'b1);
			chk(count_out, rows[i].cnt);
			chk(switch_out, rows[i].sw);
		end
		reset_in <= 1'b1;
		repeat (140) @(posedge aclk);
		chk(switch_out, 1'b0);
		pulse(4, 1'b0);
		chk(count_out, 32'h5);
		reset_in <= 1'b0;
		repeat (140) @(posedge aclk);
		chk(switch_out, 1'b1);
		on_ext <= 32'h6;
		off_ext <= 32'h9;
		wr(`UDTC_OFF_CTRL, 32'he, 2'h0);
		repeat (140) @(posedge aclk);
		chk(switch_out, 1'b0);
		on_ext <= 32'h1;
		off_ext <= 32'hffffffff;
		repeat (140) @(posedge aclk);
		chk(switch_out, 1'b1);
		wr(`UDTC_OFF_CTRL, 32'h9, 2'h0);
		pulse(2, 1'b0);
		pin(1'b1);
		chk(count_out, 32'h7);
		wr(`UDTC_OFF_CTRL, 32'h8, 2'h0);
		pin(1'b1);
		chk(count_out, 32'h5);
		wr(`UDTC_OFF_CTRL, 32'h18, 2'h0);
		pulse(1, 1'b1);
		chk(count_out, 32'h5);
		rd(`UDTC_OFF_COUNT, 32'h5, 2'h0);
		rd(`UDTC_OFF_STATUS, 32'h4, 2'h0);
		wr(`UDTC_OFF_CTRL, 32'h0, 2'h0);
		pin(1'b0);
		chk(count_out, 32'h0);
		summarize();
	end
endmodule // tb_udtc_top
`default_nettype wire

// ==== testbench/udtc_src.sv ====
// Purpose: upstream pulse source driving the count and direction pins
// Assumes: runs on aclk, one burst at a time
// Notes: direction settles before the first rising edge of a burst
`timescale 1ns/1ps
`default_nettype none
module udtc_src (
	input wire logic aclk,
	input wire logic start,
	input wire logic [7:0] num,
	input wire logic dir,
	output logic count_in,
	output logic dir_in,
	output logic busy
);
	logic [7:0] left_q = 8'h00;
	logic [2:0] ph_q = 3'h0;
	always_ff @(posedge aclk) begin
		if (start && !busy) begin
			left_q <= num;
			ph_q <= 3'h0;
			dir_in <= dir;
		end else if (busy) begin
			ph_q <= ph_q + 3'h1;
			if (ph_q == 3'h7)
				left_q <= left_q - 8'h01;
		end
	end
	// Slow source only, eight cycles a pulse
	assign count_in = busy && ph_q[2];
	assign busy = left_q != 8'h00;
endmodule // udtc_src
`default_nettype wire

// ==== verilog/udtc_cfg.svh ====
// Purpose: constants for the up/down threshold counter
// Assumes: 125 MHz aclk, AXI4-Lite register map of our own
// Notes: offsets are byte addresses
`ifndef UDTC_CFG_SVH
`define UDTC_CFG_SVH
`define UDTC_OFF_CTRL 8'h00
`define UDTC_OFF_INIT 8'h04
`define UDTC_OFF_ON_THR 8'h08
`define UDTC_OFF_OFF_THR 8'h0c
`define UDTC_OFF_COUNT 8'h10
`define UDTC_OFF_STATUS 8'h14
`define UDTC_CTRL_RETAIN 0
`define UDTC_CTRL_ON_SRC 1
`define UDTC_CTRL_OFF_SRC 2
`define UDTC_CTRL_USE_INIT 3
`define UDTC_CTRL_SW_RESET 4
`define UDTC_THR_MAX 32'h0098967f
`define UDTC_RST_CTRL 5'h08
`define UDTC_RST_VAL 32'h00000000
`define UDTC_SCAN_NS 32'd1000
`define UDTC_CLK_NS 32'd8
`define UDTC_SCAN_CYC ((`UDTC_SCAN_NS + `UDTC_CLK_NS - 32'd1) / `UDTC_CLK_NS)
`endif

// ==== verilog/udtc_edge.sv ====
// Purpose: synchroniser and rising edge detector for one pin
// Assumes: pin is asynchronous to aclk
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module udtc_edge (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pin,
	output logic level,
	output logic rise
);
	logic s1_q;
	logic s2_q;
	logic prev_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			prev_q <= s2_q;
		end
	end
	assign level = s2_q;
	// Compare with previous sample so a level counts once
	assign rise = s2_q & ~prev_q; // [RULE14] [RULE1]
endmodule // udtc_edge
`default_nettype wire

// ==== verilog/udtc_pkg.sv ====
// Purpose: types for the up/down threshold counter
// Assumes: nothing
// Notes: count is signed so down counting can go below zero
package udtc_pkg;
	typedef logic signed [31:0] udtc_cnt_t;
	typedef logic [31:0] udtc_word_t;
	typedef enum logic [2:0] {
		UDTC_IDLE = 3'b001,
		UDTC_WDATA = 3'b010,
		UDTC_RESP = 3'b100
	} udtc_wr_e;
endpackage

// ==== verilog/udtc_top.sv ====
// Purpose: up/down event counter with hysteresis or window output
// Assumes: one aclk; pins synchronised here; AXI4-Lite slave
// Notes: thresholds compared once per scan tick only
// How it works
// RULE1 - Only rising edges of count input count
// RULE2 - Edge adds one, or subtracts when direction high
// RULE3 - Reset reloads initial count, clears output
// RULE4 - While reset high, output low, edges ignored
// RULE5 - Thresholds hold zero up to 9999999
// RULE6 - Initial count is start and reset value
// RULE7 - Retain option keeps count over power loss
// RULE8 - On>=Off: hysteresis set and clear
// RULE9 - On<Off: high inside window only
// RULE10 - Compare only once per scan tick
// RULE11 - Thresholds may come from external values
// RULE12 - Fast pulses only on fast terminals
// RULE13 - Reduced variant always starts from zero
// RULE14 - Edges found by comparing with prior sample
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "udtc_cfg.svh"
module udtc_top
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic count_in,
	input wire logic dir_in,
	input wire logic reset_in,
	input wire logic power_up,
	input wire udtc_pkg::udtc_word_t on_ext,
	input wire udtc_pkg::udtc_word_t off_ext,
	output logic switch_out,
	output udtc_pkg::udtc_cnt_t count_out,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import udtc_pkg::*;

	function automatic udtc_word_t clamp_thr(input udtc_word_t v);
		clamp_thr = (v > `UDTC_THR_MAX) ? `UDTC_THR_MAX : v;
	endfunction

	function automatic udtc_word_t merge(input udtc_word_t old, input udtc_word_t nw,
		input logic [3:0] be);
		udtc_word_t r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		merge = r;
	endfunction

	logic cnt_level;
	logic cnt_rise;
	logic dir_s1_q;
	logic dir_s2_q;
	logic rst_s1_q;
	logic rst_s2_q;
	logic pwr_s1_q;
	logic pwr_s2_q;
	logic pwr_prev_q;
	logic [4:0] ctrl_q;
	udtc_word_t init_q;
	udtc_word_t on_q;
	udtc_word_t off_q;
	udtc_cnt_t count_q;
	logic out_q;
	logic [31:0] scan_q;
	logic tick;
	udtc_wr_e wr_q;
	logic [7:0] awaddr_q;
	logic aw_got_q;
	logic w_got_q;
	udtc_word_t wdata_q;
	logic [3:0] wstrb_q;
	logic rst_act;
	logic pwr_rise;
	udtc_word_t on_thr;
	udtc_word_t off_thr;
	udtc_cnt_t start_val;

	udtc_edge u_cnt_edge (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(count_in),
		.level(cnt_level),
		.rise(cnt_rise)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dir_s1_q <= 1'b0;
			dir_s2_q <= 1'b0;
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
			pwr_s1_q <= 1'b0;
			pwr_s2_q <= 1'b0;
			pwr_prev_q <= 1'b0;
		end else begin
			dir_s1_q <= dir_in;
			dir_s2_q <= dir_s1_q;
			rst_s1_q <= reset_in;
			rst_s2_q <= rst_s1_q;
			pwr_s1_q <= power_up;
			pwr_s2_q <= pwr_s1_q;
			pwr_prev_q <= pwr_s2_q;
		end
	end

	assign rst_act = rst_s2_q | ctrl_q[`UDTC_CTRL_SW_RESET];
	assign pwr_rise = pwr_s2_q & ~pwr_prev_q;
	// Threshold source select; external values clamped to range
	assign on_thr = ctrl_q[`UDTC_CTRL_ON_SRC] ? clamp_thr(on_ext) : on_q; // [RULE11]
	assign off_thr = ctrl_q[`UDTC_CTRL_OFF_SRC] ? clamp_thr(off_ext) : off_q; // [RULE11]
	// Without the initial-count option the start is zero
	assign start_val = ctrl_q[`UDTC_CTRL_USE_INIT] ? udtc_cnt_t'(init_q) : '0; // [RULE6] [RULE13]

	// Scan tick divider
	assign tick = (scan_q == `UDTC_SCAN_CYC - 32'd1);
	always_ff @(posedge aclk) begin
		if (!aresetn || tick) begin
			scan_q <= 32'h00000000;
		end else begin
			scan_q <= scan_q + 32'd1;
		end
	end

	// Count register; edges counted each clock, not per tick, so none are lost
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_q <= '0;
		end else if (rst_act) begin
			count_q <= start_val; // [RULE3] [RULE4]
		end else if (pwr_rise && !ctrl_q[`UDTC_CTRL_RETAIN]) begin
			count_q <= start_val; // [RULE7]
		end else if (cnt_rise) begin
			count_q <= dir_s2_q ? count_q - 32'sd1 : count_q + 32'sd1; // [RULE2] [RULE1]
		end
	end

	// Output only re-evaluated on the scan tick
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_q <= 1'b0;
		end else if (rst_act) begin
			out_q <= 1'b0; // [RULE3] [RULE4]
		end else if (pwr_rise && !ctrl_q[`UDTC_CTRL_RETAIN]) begin
			out_q <= 1'b0; // [RULE7]
		end else if (tick) begin // [RULE10]
			if (on_thr >= off_thr) begin
				if (count_q >= $signed(on_thr)) begin
					out_q <= 1'b1; // [RULE8]
				end else if (count_q < $signed(off_thr)) begin
					out_q <= 1'b0; // [RULE8]
				end
			end else begin
				out_q <= (count_q >= $signed(on_thr)) && (count_q < $signed(off_thr)); // [RULE9]
			end
		end
	end

	assign switch_out = out_q;
	assign count_out = count_q;

	// AXI4-Lite write path: address and data in either order
	// Readies are flops; each drops while its half is held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_q <= UDTC_IDLE;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= '0;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end else begin
			case (wr_q)
				UDTC_IDLE, UDTC_WDATA: begin
					if (s_axi_awvalid && s_axi_awready) begin
						aw_got_q <= 1'b1;
						awaddr_q <= s_axi_awaddr;
						s_axi_awready <= 1'b0;
					end
					if (s_axi_wvalid && s_axi_wready) begin
						w_got_q <= 1'b1;
						wdata_q <= s_axi_wdata;
						wstrb_q <= s_axi_wstrb;
						s_axi_wready <= 1'b0;
					end
					if (aw_got_q && w_got_q) begin
						wr_q <= UDTC_RESP;
						s_axi_bvalid <= 1'b1;
						case (awaddr_q)
							`UDTC_OFF_CTRL, `UDTC_OFF_INIT, `UDTC_OFF_ON_THR,
							`UDTC_OFF_OFF_THR: s_axi_bresp <= 2'h0;
							default: s_axi_bresp <= 2'h2;
						endcase
					end else begin
						wr_q <= UDTC_WDATA;
					end
				end
				UDTC_RESP: begin
					if (s_axi_bready) begin
						s_axi_bvalid <= 1'b0;
						aw_got_q <= 1'b0;
						w_got_q <= 1'b0;
						s_axi_awready <= 1'b1;
						s_axi_wready <= 1'b1;
						wr_q <= UDTC_IDLE;
					end
				end
				default: wr_q <= UDTC_IDLE;
			endcase
		end
	end

	// Register stores, committed when both halves are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= `UDTC_RST_CTRL;
			init_q <= `UDTC_RST_VAL;
			on_q <= `UDTC_RST_VAL;
			off_q <= `UDTC_RST_VAL;
		end else if (wr_q != UDTC_RESP && aw_got_q && w_got_q) begin
			case (awaddr_q)
				`UDTC_OFF_CTRL: ctrl_q <= 5'(merge({27'h0, ctrl_q}, wdata_q, wstrb_q));
				`UDTC_OFF_INIT: init_q <= merge(init_q, wdata_q, wstrb_q);
				`UDTC_OFF_ON_THR: on_q <= clamp_thr(merge(on_q, wdata_q, wstrb_q)); // [RULE5]
				`UDTC_OFF_OFF_THR: off_q <= clamp_thr(merge(off_q, wdata_q, wstrb_q)); // [RULE5]
				default: ctrl_q <= ctrl_q;
			endcase
		end
	end

	// Read path, one read at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
			s_axi_arready <= 1'b1;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_arready <= 1'b0;
			s_axi_rresp <= 2'h0;
			case (s_axi_araddr)
				`UDTC_OFF_CTRL: s_axi_rdata <= {27'h0, ctrl_q};
				`UDTC_OFF_INIT: s_axi_rdata <= init_q;
				`UDTC_OFF_ON_THR: s_axi_rdata <= on_q;
				`UDTC_OFF_OFF_THR: s_axi_rdata <= off_q;
				`UDTC_OFF_COUNT: s_axi_rdata <= count_q;
				`UDTC_OFF_STATUS: s_axi_rdata <= {29'h0, dir_s2_q, cnt_level, out_q};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'h2;
				end
			endcase
		end
	end

	// Outside reset and power return, count moves only on a counted edge, by one
	a_edge_only: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE1]
		(!cnt_rise && !rst_act && !pwr_rise) |=> $stable(count_q))
		else $error("count moved without a rising edge");
	a_rise_once: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE14]
		cnt_rise |-> cnt_level && !$past(cnt_level))
		else $error("edge seen without a low to high step");
	a_step_size: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE2]
		(cnt_rise && !rst_act && !pwr_rise) |=>
		(count_q == $past(count_q) + ($past(dir_s2_q) ? -32'sd1 : 32'sd1)))
		else $error("count step wrong");

	// Reset and power return
	a_reset_load: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE3]
		rst_act |=> (count_q == $past(start_val)) && !out_q)
		else $error("reset did not reload");
	// Start value may be rewritten during reset, so only a steady one is held
	a_reset_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE4]
		(rst_act [*2] ##0 $stable(start_val)) |=> !out_q && $stable(count_q))
		else $error("counting during reset");
	a_zero_start: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE13]
		(rst_act && !ctrl_q[`UDTC_CTRL_USE_INIT]) |=> count_q == 0)
		else $error("reduced start not zero");
	a_retain_keep: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE7]
		(pwr_rise && ctrl_q[`UDTC_CTRL_RETAIN] && !rst_act && !cnt_rise) |=> $stable(count_q))
		else $error("retained count lost");
	a_pwr_reload: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE7]
		(pwr_rise && !ctrl_q[`UDTC_CTRL_RETAIN] && !rst_act) |=>
		(count_q == $past(start_val)) && !out_q)
		else $error("power return did not reload");

	// Thresholds and switching output
	a_thr_range: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE5]
		(on_q <= `UDTC_THR_MAX) && (off_q <= `UDTC_THR_MAX))
		else $error("threshold out of range");
	a_thr_live: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE11]
		(on_thr <= `UDTC_THR_MAX) && (off_thr <= `UDTC_THR_MAX))
		else $error("selected threshold out of range");
	a_hyst_set: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE8]
		(tick && !rst_act && !pwr_rise && on_thr >= off_thr && count_q >= $signed(on_thr))
		|=> out_q)
		else $error("hysteresis did not set");
	a_hyst_clear: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE8]
		(tick && !rst_act && !pwr_rise && on_thr >= off_thr && count_q < $signed(off_thr))
		|=> !out_q)
		else $error("hysteresis did not clear");
	a_hyst_keep: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE8]
		(tick && !rst_act && !pwr_rise && on_thr >= off_thr
		&& count_q >= $signed(off_thr) && count_q < $signed(on_thr))
		|=> $stable(out_q))
		else $error("hysteresis band changed output");
	a_window_out: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE9]
		(tick && !rst_act && !pwr_rise && on_thr < off_thr) |=>
		out_q == ($past(count_q) >= $signed($past(on_thr))
		&& $past(count_q) < $signed($past(off_thr))))
		else $error("window output wrong");
	a_tick_only: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE10]
		(!tick && !rst_act && !pwr_rise) |=> $stable(out_q))
		else $error("output changed off tick");
endmodule // udtc_top
`default_nettype wire
